// ---- rtl/two_wire_slave_and_bitbang_port.sv ----
// Two-wire hardware slave with software bit-bang master port
//
// Behaviour
// - Own address resets to 55H, seven bits
// - Received byte latched into byte buffer
// - Buffer write supplies byte shifted out
// - Buffer read or write clears done flag
// - Data-out bit drives data pin when enabled
// - Drive-enable selects data pin output or input
// - Master mode: clock pin always driven from clock-out bit
// - Data-in samples line on clock rise, undriven
// - Master-select picks bit-bang or hardware slave
// - Interface reset bit returns slave to idle
// - Direction bit loaded from read/write bit
// - Flag raised after start, address, R/W
// - Idle slave waits for start condition
// - Interrupt needs peripheral and global enables
// - Interrupt vectors to 003BH per byte
// - First byte in buffer is address plus R/W
// - Clock held low while flag is set
// - Flag only for acknowledged bytes
// - Flags continue until stop, not-acknowledge or reset
// - Master mode never raises flag or interrupt
// - Two-wire active only while select bit clear
// - Address compared zero-extended to own address
// - Ninth pulse acknowledges only on match
// - Stop or not-acknowledge returns to idle
// - Data edge with clock high: start/stop
`timescale 1ns/1ps
module two_wire_slave_and_bitbang_port
  import twi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_serial_periph_select,
  input wire logic i_irq_enable,
  input wire logic i_global_irq_enable,
  output logic o_irq_request,
  output logic [15:0] o_irq_vector,
  input wire logic i_scl_in,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe
);

  line_sync_if line_bus ();

  line_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_scl_pin(i_scl_in),
    .i_sda_pin(i_sda_in),
    .sync_bus(line_bus)
  );

  // Register file
  logic [7:0] own_address_reg_ff;
  logic [7:0] byte_buffer_reg_ff;
  logic master_data_out_ff;
  logic master_data_drive_enable_ff;
  logic master_clock_out_ff;
  logic master_data_in_ff;
  logic master_select_ff;
  logic transfer_direction_ff;
  logic byte_done_flag_ff;
  logic interface_reset_bit_ff;

  // Slave engine
  slave_state_t state_ff;
  slave_state_t nxt_state;
  logic [7:0] shift_ff;
  logic [3:0] bit_count_ff;
  logic slave_sda_low_ff;

  // Output registers
  logic [7:0] sfr_rdata_ff;
  logic irq_request_ff;
  logic [15:0] irq_vector_ff;
  logic scl_out_ff;
  logic scl_oe_ff;
  logic sda_out_ff;
  logic sda_oe_ff;

  logic wr_own;
  logic wr_buf;
  logic rd_buf;
  logic wr_ctl;
  logic two_wire_on;
  logic slave_on;
  logic start_seen;
  logic stop_seen;
  logic addr_match;
  logic byte_event;
  logic flag_clear;
  logic engine_reset;
  logic [7:0] ctl_view;

  assign wr_own = i_sfr_wr && (i_sfr_addr == SFR_OWN_ADDRESS);
  assign wr_buf = i_sfr_wr && (i_sfr_addr == SFR_BYTE_BUFFER);
  assign rd_buf = i_sfr_rd && (i_sfr_addr == SFR_BYTE_BUFFER);
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == SFR_CONTROL_STATUS);

  assign two_wire_on = !i_serial_periph_select;
  assign slave_on = two_wire_on && !master_select_ff;

  assign start_seen = line_bus.sda_fall && line_bus.scl_level;
  assign stop_seen = line_bus.sda_rise && line_bus.scl_level;

  assign addr_match = ({1'b0, shift_ff[7:1]} == own_address_reg_ff);

  assign engine_reset = interface_reset_bit_ff || !slave_on;

  assign flag_clear = wr_buf || rd_buf ||
                      (wr_ctl && !i_sfr_wdata[CTL_BYTE_DONE_BIT]);

  // Flag at end of an acknowledged ninth pulse
  assign byte_event = slave_on && line_bus.scl_fall &&
                      ((state_ff == st_addr_ack) ||
                       (state_ff == st_rx_ack) ||
                       ((state_ff == st_tx_ack) && !shift_ff[0]));

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      own_address_reg_ff <= OWN_ADDRESS_RESET;
    end else if (wr_own) begin
      own_address_reg_ff <= i_sfr_wdata;
    end
  end

  // Software control bits; reset bit self-clears next cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      master_data_out_ff <= 1'b0;
      master_data_drive_enable_ff <= 1'b0;
      master_clock_out_ff <= 1'b0;
      master_select_ff <= 1'b0;
      interface_reset_bit_ff <= 1'b0;
    end else begin
      interface_reset_bit_ff <= wr_ctl && i_sfr_wdata[CTL_IF_RESET_BIT];
      if (wr_ctl) begin
        master_data_out_ff <= i_sfr_wdata[CTL_DATA_OUT_BIT];
        master_data_drive_enable_ff <= i_sfr_wdata[CTL_DRIVE_EN_BIT];
        master_clock_out_ff <= i_sfr_wdata[CTL_CLOCK_OUT_BIT];
        master_select_ff <= i_sfr_wdata[CTL_MASTER_SEL_BIT];
      end
    end
  end

  // Data-in sampled on clock rise while undriven
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      master_data_in_ff <= 1'b0;
    end else if (two_wire_on && master_select_ff && line_bus.scl_rise &&
                 !master_data_drive_enable_ff) begin
      master_data_in_ff <= line_bus.sda_level;
    end
  end

  // Byte buffer: software writes, or received byte lands here
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      byte_buffer_reg_ff <= BYTE_BUFFER_RESET;
    end else if (slave_on && line_bus.scl_rise &&
                 bit_count_ff == BITS_PER_BYTE - BIT_COUNT_ONE &&
                 (state_ff == st_addr || state_ff == st_rx)) begin
      // First byte is address plus R/W
      byte_buffer_reg_ff <= {shift_ff[6:0], line_bus.sda_level};
    end else if (wr_buf) begin
      byte_buffer_reg_ff <= i_sfr_wdata;
    end
  end

  // Direction from the R/W bit of a matched address
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || interface_reset_bit_ff) begin
      transfer_direction_ff <= 1'b0;
    end else if (slave_on && state_ff == st_addr && addr_match &&
                 bit_count_ff == BITS_PER_BYTE) begin
      transfer_direction_ff <= shift_ff[0];
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || interface_reset_bit_ff) begin
      byte_done_flag_ff <= 1'b0;
    end else if (byte_event) begin
      byte_done_flag_ff <= 1'b1;
    end else if (flag_clear || (two_wire_on && master_select_ff)) begin
      byte_done_flag_ff <= 1'b0;
    end
  end

  // Slave sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        nxt_state = st_idle;
      end
      st_addr: begin
        if (line_bus.scl_fall && bit_count_ff == BITS_PER_BYTE) begin
          nxt_state = addr_match ? st_addr_ack : st_ignore;
        end
      end
      st_addr_ack: begin
        if (line_bus.scl_fall) begin
          nxt_state = transfer_direction_ff ? st_tx : st_rx;
        end
      end
      st_rx: begin
        if (line_bus.scl_fall && bit_count_ff == BITS_PER_BYTE) begin
          nxt_state = st_rx_ack;
        end
      end
      st_rx_ack: begin
        if (line_bus.scl_fall) begin
          nxt_state = st_rx;
        end
      end
      st_tx: begin
        if (line_bus.scl_fall && bit_count_ff == BITS_PER_BYTE) begin
          nxt_state = st_tx_ack;
        end
      end
      st_tx_ack: begin
        if (line_bus.scl_fall) begin
          nxt_state = shift_ff[0] ? st_idle : st_tx;
        end
      end
      st_ignore: begin
        nxt_state = st_ignore;
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
    if (stop_seen) begin
      nxt_state = st_idle;
    end
    if (start_seen) begin
      // Repeated start restarts addressing
      nxt_state = st_addr;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || engine_reset) begin
      state_ff <= st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit counter counts clock rises within a byte
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || engine_reset || start_seen) begin
      bit_count_ff <= BIT_COUNT_ZERO;
    end else if (line_bus.scl_rise &&
                 (state_ff == st_addr || state_ff == st_rx ||
                  state_ff == st_tx)) begin
      bit_count_ff <= bit_count_ff + BIT_COUNT_ONE;
    end else if (line_bus.scl_fall && (state_ff == st_addr_ack ||
                 state_ff == st_rx_ack || state_ff == st_tx_ack)) begin
      bit_count_ff <= BIT_COUNT_ZERO;
    end
  end

  // Shift register: receives on rise, transmits MSB first
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || engine_reset) begin
      shift_ff <= SHIFT_RESET;
    end else if (state_ff == st_tx && bit_count_ff == BIT_COUNT_ZERO &&
                 wr_buf) begin
      // Written byte becomes the outgoing byte
      shift_ff <= i_sfr_wdata;
    end else if (line_bus.scl_rise) begin
      case (state_ff)
        st_addr, st_rx: begin
          shift_ff <= {shift_ff[6:0], line_bus.sda_level};
        end
        st_tx_ack: begin
          // Master's acknowledge parked in bit 0
          shift_ff <= {shift_ff[7:1], line_bus.sda_level};
        end
        default: begin
          shift_ff <= shift_ff;
        end
      endcase
    end else if (line_bus.scl_fall && state_ff == st_tx) begin
      shift_ff <= {shift_ff[6:0], 1'b0};
    end
  end

  // Slave pull on the data line, decided from the next state
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || engine_reset) begin
      slave_sda_low_ff <= 1'b0;
    end else begin
      case (nxt_state)
        st_addr_ack, st_rx_ack: begin
          slave_sda_low_ff <= 1'b1;
        end
        st_tx: begin
          if (state_ff == st_tx && wr_buf &&
              bit_count_ff == BIT_COUNT_ZERO) begin
            slave_sda_low_ff <= !i_sfr_wdata[7];
          end else if (line_bus.scl_fall) begin
            slave_sda_low_ff <= (bit_count_ff == BITS_PER_BYTE) ? 1'b0 :
                                !shift_ff[6];
          end
        end
        default: begin
          // Transmitter releases data during master ack
          slave_sda_low_ff <= 1'b0;
        end
      endcase
    end
  end

  // Pin drivers; enable high means this end drives
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || !two_wire_on) begin
      scl_out_ff <= 1'b1;
      scl_oe_ff <= 1'b0;
      sda_out_ff <= 1'b1;
      sda_oe_ff <= 1'b0;
    end else if (master_select_ff) begin
      // Clock driver always on in master mode
      scl_out_ff <= master_clock_out_ff;
      scl_oe_ff <= 1'b1;
      sda_out_ff <= master_data_out_ff;
      sda_oe_ff <= master_data_drive_enable_ff;
    end else begin
      scl_out_ff <= 1'b0;
      scl_oe_ff <= byte_done_flag_ff || byte_event;
      sda_out_ff <= 1'b0;
      sda_oe_ff <= slave_sda_low_ff;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      irq_request_ff <= 1'b0;
      irq_vector_ff <= IRQ_VECTOR_NONE;
    end else begin
      irq_request_ff <= byte_done_flag_ff && i_irq_enable &&
                        i_global_irq_enable;
      irq_vector_ff <= (byte_done_flag_ff && i_irq_enable &&
                        i_global_irq_enable) ? IRQ_VECTOR : IRQ_VECTOR_NONE;
    end
  end

  always_comb begin
    ctl_view = READ_RESET;
    ctl_view[CTL_DATA_OUT_BIT] = master_data_out_ff;
    ctl_view[CTL_DRIVE_EN_BIT] = master_data_drive_enable_ff;
    ctl_view[CTL_CLOCK_OUT_BIT] = master_clock_out_ff;
    ctl_view[CTL_DATA_IN_BIT] = master_data_in_ff;
    ctl_view[CTL_MASTER_SEL_BIT] = master_select_ff;
    ctl_view[CTL_DIRECTION_BIT] = transfer_direction_ff;
    ctl_view[CTL_BYTE_DONE_BIT] = byte_done_flag_ff;
  end

  // Registered read; clock line level is deliberately not visible
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sfr_rdata_ff <= READ_RESET;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        SFR_OWN_ADDRESS: begin
          sfr_rdata_ff <= own_address_reg_ff;
        end
        SFR_BYTE_BUFFER: begin
          sfr_rdata_ff <= byte_buffer_reg_ff;
        end
        SFR_CONTROL_STATUS: begin
          sfr_rdata_ff <= ctl_view;
        end
        default: begin
          sfr_rdata_ff <= READ_RESET;
        end
      endcase
    end
  end

  assign o_sfr_rdata = sfr_rdata_ff;
  assign o_irq_request = irq_request_ff;
  assign o_irq_vector = irq_vector_ff;
  assign o_scl_out = scl_out_ff;
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_out = sda_out_ff;
  assign o_sda_oe = sda_oe_ff;

endmodule : two_wire_slave_and_bitbang_port

// ---- rtl/twi_pkg.sv ----
// Shared constants and types for the two-wire slave and bit-bang port
package twi_pkg;

  // Special-function register addresses
  localparam logic [7:0] SFR_OWN_ADDRESS = 8'h9B;
  localparam logic [7:0] SFR_BYTE_BUFFER = 8'h9A;
  localparam logic [7:0] SFR_CONTROL_STATUS = 8'hE8;

  // Reset values
  localparam logic [7:0] OWN_ADDRESS_RESET = 8'h55;
  localparam logic [7:0] BYTE_BUFFER_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] READ_RESET = 8'h00;

  // Control/status field positions
  localparam int CTL_DATA_OUT_BIT = 7;
  localparam int CTL_DRIVE_EN_BIT = 6;
  localparam int CTL_CLOCK_OUT_BIT = 5;
  localparam int CTL_DATA_IN_BIT = 4;
  localparam int CTL_MASTER_SEL_BIT = 3;
  localparam int CTL_IF_RESET_BIT = 2;
  localparam int CTL_DIRECTION_BIT = 1;
  localparam int CTL_BYTE_DONE_BIT = 0;

  // Byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_COUNT_ONE = 4'h1;

  // Interrupt vector presented with each request
  localparam logic [15:0] IRQ_VECTOR = 16'h003B;
  localparam logic [15:0] IRQ_VECTOR_NONE = 16'h0000;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_rx,
    st_rx_ack,
    st_tx,
    st_tx_ack,
    st_ignore
  } slave_state_t;

endpackage : twi_pkg

// ---- rtl/line_sync_if.sv ----
// Filtered line levels and edges passed from the pin synchroniser
`timescale 1ns/1ps
interface line_sync_if;
  logic scl_level;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;

  modport source (
    output scl_level, sda_level, scl_rise, scl_fall, sda_rise, sda_fall
  );
  modport sink (
    input scl_level, sda_level, scl_rise, scl_fall, sda_rise, sda_fall
  );
endinterface : line_sync_if

// ---- rtl/line_pin_sync.sv ----
// Three-stage synchroniser and agreement filter for clock and data pins
`timescale 1ns/1ps
module line_pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_scl_pin,
  input wire logic i_sda_pin,
  line_sync_if.source sync_bus
);

  logic [1:0] pins;
  logic [1:0] stage1_ff;
  logic [1:0] stage2_ff;
  logic [1:0] stage3_ff;
  logic [1:0] level_ff;
  logic [1:0] rise;
  logic [1:0] fall;

  assign pins = {i_sda_pin, i_scl_pin};

  // Lines idle high on an open-drain bus
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      stage1_ff <= 2'h3;
      stage2_ff <= 2'h3;
      stage3_ff <= 2'h3;
    end else begin
      stage1_ff <= pins;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      // Level moves only when the two late stages agree
      always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
          level_ff[g] <= 1'b1;
        end else if (stage2_ff[g] == stage3_ff[g]) begin
          level_ff[g] <= stage3_ff[g];
        end
      end
      assign rise[g] = (stage2_ff[g] == stage3_ff[g]) && stage3_ff[g] &&
                       !level_ff[g];
      assign fall[g] = (stage2_ff[g] == stage3_ff[g]) && !stage3_ff[g] &&
                       level_ff[g];
    end
  endgenerate

  assign sync_bus.scl_level = level_ff[0];
  assign sync_bus.sda_level = level_ff[1];
  assign sync_bus.scl_rise = rise[0];
  assign sync_bus.scl_fall = fall[0];
  assign sync_bus.sda_rise = rise[1];
  assign sync_bus.sda_fall = fall[1];

endmodule : line_pin_sync

// ---- verification/twi_port_chk.sv ----
// Port assertions for the two-wire slave and bit-bang port
`timescale 1ns/1ps
module twi_port_chk
  import twi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_serial_periph_select,
  input wire logic i_irq_enable,
  input wire logic i_global_irq_enable,
  input wire logic o_irq_request,
  input wire logic [15:0] o_irq_vector,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe
);
  // Shadow of the last control write, mode bit included
  logic [7:0] ctl_ff;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ctl_ff <= 8'h00;
    end else if (i_sfr_wr && i_sfr_addr == SFR_CONTROL_STATUS) begin
      ctl_ff <= i_sfr_wdata;
    end
  end

  property p_reset_idle;
    $rose(i_resetn) |-> !o_sda_oe && !o_scl_oe && !o_irq_request;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("busy at reset");

  property p_irq_enables;
    o_irq_request |-> $past(i_irq_enable) && $past(i_global_irq_enable);
  endproperty
  a_irq_enables: assert property (p_irq_enables)
    else $error("irq gate");

  property p_irq_vector;
    o_irq_vector == (o_irq_request ? IRQ_VECTOR : IRQ_VECTOR_NONE);
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("vector");

  property p_stretch;
    o_irq_request [*2] |-> o_scl_oe && !o_scl_out;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");

  property p_master_scl;
    ctl_ff[CTL_MASTER_SEL_BIT] && $stable(ctl_ff) && !i_serial_periph_select
      && !$past(i_serial_periph_select)
      |-> o_scl_oe && o_scl_out == ctl_ff[CTL_CLOCK_OUT_BIT];
  endproperty
  a_master_scl: assert property (p_master_scl) else $error("clock pin");

  property p_master_sda;
    ctl_ff[CTL_MASTER_SEL_BIT] && $stable(ctl_ff) && !i_serial_periph_select
      && !$past(i_serial_periph_select)
      |-> o_sda_oe == ctl_ff[CTL_DRIVE_EN_BIT]
      && (!o_sda_oe || o_sda_out == ctl_ff[CTL_DATA_OUT_BIT]);
  endproperty
  a_master_sda: assert property (p_master_sda)
    else $error("data pin");

  property p_master_quiet;
    ctl_ff[CTL_MASTER_SEL_BIT] [*3] |-> !o_irq_request;
  endproperty
  a_master_quiet: assert property (p_master_quiet) else $error("irq");

  property p_slave_low;
    !ctl_ff[CTL_MASTER_SEL_BIT] && !$past(ctl_ff[CTL_MASTER_SEL_BIT])
      && o_sda_oe |-> !o_sda_out;
  endproperty
  a_slave_low: assert property (p_slave_low) else $error("drove high");

  property p_periph_release;
    i_serial_periph_select && $past(i_serial_periph_select)
      |-> !o_sda_oe && !o_scl_oe;
  endproperty
  a_periph_release: assert property (p_periph_release)
    else $error("pins");
endmodule : twi_port_chk

bind two_wire_slave_and_bitbang_port twi_port_chk chk (
  .i_clk_sys, .i_resetn, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
  .i_serial_periph_select, .i_irq_enable, .i_global_irq_enable,
  .o_irq_request, .o_irq_vector, .o_scl_out, .o_scl_oe, .o_sda_out,
  .o_sda_oe
);

// ---- verification/twi_master_model.sv ----
// Behavioural two-wire bus master facing the slave
`timescale 1ns/1ps
module twi_master_model (
  input wire logic i_scl_line,
  input wire logic i_sda_line,
  output logic o_scl_drive,
  output logic o_sda_drive
);
  // Quarter of the 125 ns bit period
  localparam realtime QTR = 31.25;

  initial begin
    o_scl_drive = 1'b1;
    o_sda_drive = 1'b1;
  end

  // data moves only while clock is low
  task automatic clock_bit(input logic b, output logic r);
    int n;
    n = 0;
    #QTR o_sda_drive = b;
    #QTR o_scl_drive = 1'b1;
    // Slave may stretch the low phase
    while (!i_scl_line && n < 5000) begin
      #10;
      n++;
    end
    #(2 * QTR) r = i_sda_line;
    o_scl_drive = 1'b0;
  endtask : clock_bit

  // start is data falling with clock high
  task automatic start();
    #QTR o_sda_drive = 1'b1;
    #QTR o_scl_drive = 1'b1;
    #(2 * QTR) o_sda_drive = 1'b0;
    #(2 * QTR) o_scl_drive = 1'b0;
  endtask : start

  // stop is data rising with clock high
  task automatic stop();
    #QTR o_sda_drive = 1'b0;
    #QTR o_scl_drive = 1'b1;
    #(2 * QTR) o_sda_drive = 1'b1;
    #(2 * QTR);
  endtask : stop

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], r);
    clock_bit(1'b1, r);
    ack = !r;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, r);
      d[i] = r;
    end
    clock_bit(!ack, r);
  endtask : recv_byte
endmodule : twi_master_model

// ---- verification/testbench.sv ----
// Self-checking bench: registers, slave transfers, bit-bang port
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("CHECK FAILED %0t: got %h exp %h", $time, \
  got, exp); end end
module testbench
  import twi_pkg::*;
;
  localparam logic [7:0] CTL = SFR_CONTROL_STATUS;
  localparam logic [7:0] BUF = SFR_BYTE_BUFFER;
  logic clk_sys = 1'b0;
  logic resetn, sfr_wr, sfr_rd, periph_select, irq_enable, global_irq_enable;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, rx, ctl;
  logic irq_request, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda, ack;
  logic [15:0] irq_vector;
  logic [7:0] pat [3] = '{8'hE8, 8'h48, 8'h28};
  wire scl_line;
  wire sda_line;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  // Open-drain lines with pull-ups
  assign scl_line = (scl_oe ? scl_out : 1'b1) & m_scl;
  assign sda_line = (sda_oe ? sda_out : 1'b1) & m_sda;

  always #5 clk_sys = ~clk_sys;

  two_wire_slave_and_bitbang_port dut (
    .i_clk_sys(clk_sys),
    .i_resetn(resetn),
    .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr),
    .i_sfr_rd(sfr_rd),
    .i_sfr_wdata(sfr_wdata),
    .o_sfr_rdata(sfr_rdata),
    .i_serial_periph_select(periph_select),
    .i_irq_enable(irq_enable),
    .i_global_irq_enable(global_irq_enable),
    .o_irq_request(irq_request),
    .o_irq_vector(irq_vector),
    .i_scl_in(scl_line),
    .o_scl_out(scl_out),
    .o_scl_oe(scl_oe),
    .i_sda_in(sda_line),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe)
  );

  twi_master_model master (
    .i_scl_line(scl_line),
    .i_sda_line(sda_line),
    .o_scl_drive(m_scl),
    .o_sda_drive(m_sda)
  );

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_clk

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : sfr_read

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    sfr_read(a, v);
    `CHECK(v, e)
  endtask : expect_reg

  task automatic address(input logic [7:0] b, input logic exp_ack);
    master.start();
    master.send_byte(b, ack);
    `CHECK(ack, exp_ack)
    wait_clk(8);
  endtask : address

  task automatic end_frame();
    master.stop();
    wait_clk(8);
  endtask : end_frame

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // Run needs under 10000 cycles; double that means a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    resetn = 1'b0;
    {sfr_wr, sfr_rd, periph_select, global_irq_enable} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    irq_enable = 1'b1;
    wait_clk(4);
    resetn = 1'b1;
    wait_clk(6);
    expect_reg(SFR_OWN_ADDRESS, OWN_ADDRESS_RESET);
    expect_reg(CTL, 8'h00);
    expect_reg(8'h80, 8'h00);
    address(8'h88, 1'b0);
    expect_reg(CTL, 8'h00);
    end_frame();
    sfr_write(SFR_OWN_ADDRESS, 8'h44);
    expect_reg(SFR_OWN_ADDRESS, 8'h44);
    // Master writes two bytes
    address(8'h88, 1'b1);
    `CHECK(scl_oe, 1'b1)
    `CHECK(irq_request, 1'b0)
    expect_reg(CTL, 8'h01);
    global_irq_enable = 1'b1;
    wait_clk(2);
    `CHECK(irq_request, 1'b1)
    `CHECK(irq_vector, IRQ_VECTOR)
    expect_reg(BUF, 8'h88);
    wait_clk(3);
    `CHECK(scl_oe, 1'b0)
    expect_reg(CTL, 8'h00);
    master.send_byte(8'h3C, ack);
    `CHECK(ack, 1'b1)
    wait_clk(8);
    expect_reg(CTL, 8'h01);
    expect_reg(BUF, 8'h3C);
    end_frame();
    master.send_byte(8'h88, ack);
    `CHECK(ack, 1'b0)
    end_frame();
    // Master reads: ack then nack
    address(8'h89, 1'b1);
    expect_reg(CTL, 8'h03);
    sfr_write(BUF, 8'hA5);
    master.recv_byte(1'b1, rx);
    `CHECK(rx, 8'hA5)
    wait_clk(8);
    expect_reg(CTL, 8'h03);
    sfr_write(BUF, 8'h5A);
    master.recv_byte(1'b0, rx);
    `CHECK(rx, 8'h5A)
    wait_clk(8);
    `CHECK(irq_request, 1'b0)
    sfr_read(CTL, v);
    `CHECK(v[CTL_BYTE_DONE_BIT], 1'b0)
    end_frame();
    // Interface reset drops a pending byte
    address(8'h88, 1'b1);
    sfr_write(CTL, 8'h05);
    wait_clk(3);
    `CHECK(scl_oe, 1'b0)
    expect_reg(CTL, 8'h00);
    end_frame();
    periph_select = 1'b1;
    address(8'h88, 1'b0);
    end_frame();
    periph_select = 1'b0;
    foreach (pat[i]) begin
      sfr_write(CTL, pat[i]);
      wait_clk(2);
      `CHECK(scl_oe, 1'b1)
      `CHECK(scl_out, pat[i][CTL_CLOCK_OUT_BIT])
      `CHECK(sda_oe, pat[i][CTL_DRIVE_EN_BIT])
      if (pat[i][CTL_DRIVE_EN_BIT]) begin
        `CHECK(sda_out, pat[i][CTL_DATA_OUT_BIT])
      end
    end
    // Software sequences pins
    // Low, high, then low while driving: last must not capture
    for (int i = 0; i < 3; i++) begin
      master.o_sda_drive = (i == 1);
      ctl = (i == 2) ? 8'hC8 : 8'h88;
      sfr_write(CTL, ctl);
      wait_clk(6);
      sfr_write(CTL, ctl | 8'h20);
      wait_clk(6);
      sfr_read(CTL, v);
      `CHECK(v[CTL_DATA_IN_BIT], i != 0)
      `CHECK(v[CTL_BYTE_DONE_BIT], 1'b0)
    end
    master.o_sda_drive = 1'b1;
    sfr_write(CTL, 8'h00);
    wait_clk(8);
    results();
  end
endmodule : testbench
